// ===== verilog/wdog_pkg.sv
// Constants, register map and shared types of the windowed watchdog pair
package wdog_pkg;

    // Counter and prescaler widths
    localparam int CNT_W = 14;
    localparam int PRE_W = 14;
    localparam int TMO_W = 15;
    localparam int THR_W = 17;

    // Timeout lengths in counting ticks
    localparam logic [TMO_W-1:0] TMO_1024  = 15'h0400;
    localparam logic [TMO_W-1:0] TMO_4096  = 15'h1000;
    localparam logic [TMO_W-1:0] TMO_8192  = 15'h2000;
    localparam logic [TMO_W-1:0] TMO_16384 = 15'h4000;

    // Register byte offsets
    localparam logic [7:0] WDT_CFG_ADDR     = 8'h00;
    localparam logic [7:0] WDT_REFRESH_ADDR = 8'h04;
    localparam logic [7:0] WDT_STATUS_ADDR  = 8'h08;
    localparam logic [7:0] IWD_CFG_ADDR     = 8'h0C;
    localparam logic [7:0] IWD_REFRESH_ADDR = 8'h10;
    localparam logic [7:0] IWD_STATUS_ADDR  = 8'h14;
    localparam logic [7:0] IRQ_STATUS_ADDR  = 8'h18;
    localparam logic [7:0] IRQ_CLEAR_ADDR   = 8'h1C;
    localparam logic [7:0] IRQ_ENABLE_ADDR  = 8'h20;

    // Field positions
    localparam int CFG_W        = 10;
    localparam int STOP_BIT     = 10;
    localparam int LOCK_BIT     = 31;
    localparam int RUN_BIT      = 30;
    localparam int REF_ERR_BIT  = 15;
    localparam int UNDERFLOW_BIT = 14;
    localparam int IRQ_W        = 4;

    // Expiry action codes
    localparam logic ACT_RESET = 1'b0;
    localparam logic ACT_NMI   = 1'b1;

    // Configuration word; first member sits in the upper bits
    typedef struct packed {
        logic [1:0] win_end;
        logic [1:0] win_start;
        logic       action;
        logic [2:0] div_sel;
        logic [1:0] tmo_sel;
    } cfg_type;

    localparam cfg_type CFG_RESET = '0;

    // Timeout length for a selection
    function automatic logic [TMO_W-1:0] tmo_cycles(input logic [1:0] s);
        unique case (s)
            2'h0: tmo_cycles = TMO_1024;
            2'h1: tmo_cycles = TMO_4096;
            2'h2: tmo_cycles = TMO_8192;
            2'h3: tmo_cycles = TMO_16384;
        endcase
    endfunction

    // Log2 of the bus clock divider: 4,64,128,512,2048,8192
    function automatic logic [3:0] bus_shift(input logic [2:0] s);
        case (s)
            3'h0:    bus_shift = 4'h2;
            3'h1:    bus_shift = 4'h6;
            3'h2:    bus_shift = 4'h7;
            3'h3:    bus_shift = 4'h9;
            3'h4:    bus_shift = 4'hB;
            default: bus_shift = 4'hD;
        endcase
    endfunction

    // Log2 of the oscillator divider: 1,16,32,64,128,256
    function automatic logic [3:0] osc_shift(input logic [2:0] s);
        case (s)
            3'h0:    osc_shift = 4'h0;
            3'h1:    osc_shift = 4'h4;
            3'h2:    osc_shift = 4'h5;
            3'h3:    osc_shift = 4'h6;
            3'h4:    osc_shift = 4'h7;
            default: osc_shift = 4'h8;
        endcase
    endfunction

    // Count value at k quarters of the timeout range
    function automatic logic [THR_W-1:0] quarter_thr(
        input logic [TMO_W-1:0] t,
        input logic [2:0]       k);
        logic [THR_W-1:0] q;
        q = {2'h0, t} >> 2;
        quarter_thr = THR_W'(q * {14'h0, k});
    endfunction

endpackage

// ===== verilog/wdog_core.sv
// One windowed down-counting watchdog with prescaler and sticky flags
`timescale 1ns/1ps
module wdog_core #(
    parameter bit INDEP = 1'b0
) (
    // Clock and reset
    input  wire logic                      ref_clk_i,
    input  wire logic                      rstn_i,
    // Control
    input  wire wdog_pkg::cfg_type         cfg_i,
    input  wire logic                      tick_i,
    input  wire logic                      start_i,
    input  wire logic                      refresh_i,
    input  wire logic                      halt_i,
    input  wire logic                      clr_uf_i,
    input  wire logic                      clr_re_i,
    // State
    output logic [wdog_pkg::CNT_W-1:0]     count_o,
    output logic                           run_o,
    output logic                           uf_o,
    output logic                           re_o,
    output logic                           uf_ev_o,
    output logic                           re_ev_o
);
    logic [wdog_pkg::PRE_W-1:0] pre, next_pre, pre_lim;
    logic [wdog_pkg::CNT_W-1:0] count, next_count, load;
    logic run, next_run, uf, next_uf, re, next_re;
    logic uf_ev, next_uf_ev, re_ev, next_re_ev;
    logic [wdog_pkg::TMO_W-1:0] tmo;
    logic [wdog_pkg::THR_W-1:0] open_thr, close_thr, cnt_wide;
    logic [3:0] shift;
    logic ctick, in_win;

    // Next state of prescaler, counter and flags
    always_comb begin
        tmo = wdog_pkg::tmo_cycles(cfg_i.tmo_sel); // RL1
        shift = INDEP ? wdog_pkg::osc_shift(cfg_i.div_sel) // RL11
                      : wdog_pkg::bus_shift(cfg_i.div_sel); // RL2
        pre_lim = wdog_pkg::PRE_W'((14'h1 << shift) - 14'h1);
        load = wdog_pkg::CNT_W'(tmo - 15'h1);
        open_thr = wdog_pkg::quarter_thr(tmo, {1'b0, cfg_i.win_start} + 3'h1); // RL4
        close_thr = wdog_pkg::quarter_thr(tmo, {1'b0, cfg_i.win_end}); // RL5
        cnt_wide = {3'h0, count};
        in_win = (cnt_wide < open_thr) && (cnt_wide >= close_thr);
        ctick = tick_i && run && !halt_i && (pre == pre_lim); // RL12
        next_pre = pre;
        next_count = count;
        next_run = run;
        next_uf_ev = 1'b0;
        next_re_ev = 1'b0;
        if (start_i || (INDEP && refresh_i && !run)) begin
            next_run = 1'b1; // RL10 RL6
            next_count = load;
            next_pre = '0;
        end else if (refresh_i && run) begin
            if (in_win) begin
                next_count = load; // RL6
                next_pre = '0;
            end else begin
                next_re_ev = 1'b1; // RL15
            end
        end else if (ctick) begin
            next_pre = '0;
            if (count == '0) begin
                next_uf_ev = 1'b1; // RL16
                next_count = load;
            end else begin
                next_count = count - 1'b1;
            end
        end else if (tick_i && run && !halt_i) begin
            next_pre = pre + 1'b1;
        end
        // Hardware set wins over a same-cycle clear
        next_uf = (uf && !clr_uf_i) || next_uf_ev; // RL8
        next_re = (re && !clr_re_i) || next_re_ev; // RL8
    end

    // State registers
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            pre   <= '0;
            count <= '0;
            run   <= 1'b0;
            uf    <= 1'b0;
            re    <= 1'b0;
            uf_ev <= 1'b0;
            re_ev <= 1'b0;
        end else begin
            pre   <= next_pre;
            count <= next_count;
            run   <= next_run;
            uf    <= next_uf;
            re    <= next_re;
            uf_ev <= next_uf_ev;
            re_ev <= next_re_ev;
        end
    end

    // Observed state
    assign count_o = count;
    assign run_o   = run;
    assign uf_o    = uf;
    assign re_o    = re;
    assign uf_ev_o = uf_ev;
    assign re_ev_o = re_ev;
endmodule

// ===== verilog/wdog_top.sv
// Bus-clocked and oscillator-clocked watchdogs behind a Wishbone slave
//
// Overview of operation
// (RL1) Timeout is selectable as 1024, 4096, 8192 or 16384 counting ticks.
// (RL2) The bus-clocked watchdog divides the bus clock by 4 to 8192.
// (RL3) Expiry raises either a reset request or an NMI request per config.
// (RL4) The window opens at 25, 50, 75 or 100 percent, 100 meaning no limit.
// (RL5) The window closes at 0, 25, 50 or 75 percent, 0 meaning never.
// (RL6) A refresh reloads the timeout; on the oscillator one it also starts.
// (RL7) Status holds refresh error in bit 15, underflow in 14, count below.
// (RL8) Both flags stay set until software clears them after reading.
// (RL9) When enabled at start-up, later config writes have no effect.
// (RL10) Writing the bus-clocked watchdog config also starts it.
// (RL11) The oscillator watchdog divides its clock by 1 to 256.
// (RL12) With count stop on, the oscillator watchdog halts in low power.
// (RL13) The bus clock runs at least four times the divided oscillator tick.
// (RL14) Software configures a watchdog before refreshing it.
// (RL15) A refresh outside the window sets refresh error and expires.
// (RL16) An underflow sets the underflow flag and expires.
`timescale 1ns/1ps
module wdog_top #(
    parameter wdog_pkg::cfg_type BOOT_WDT_CFG = wdog_pkg::CFG_RESET,
    parameter wdog_pkg::cfg_type BOOT_IWD_CFG = wdog_pkg::CFG_RESET,
    parameter bit                BOOT_IWD_STOP = 1'b0
) (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Oscillator clock, sampled as a level
    input  wire logic        independent_osc_clock_i,
    // Low-power mode indication and start-up straps
    input  wire logic        low_power_i,
    input  wire logic        boot_wdt_en_i,
    input  wire logic        boot_iwd_en_i,
    // Requests
    output logic             irq_o,
    output logic             reset_req_o,
    output logic             nmi_req_o
);
    logic [31:0] next_dat;
    logic next_ack;
    wdog_pkg::cfg_type wdt_cfg, next_wdt_cfg;
    wdog_pkg::cfg_type iwd_cfg, next_iwd_cfg;
    logic iwd_stop, next_iwd_stop;
    logic wdt_lock, next_wdt_lock;
    logic iwd_lock, next_iwd_lock;
    logic boot_pend, next_boot_pend;
    logic osc_prev, next_osc_prev;
    logic [wdog_pkg::IRQ_W-1:0] irq_stat, next_irq_stat;
    logic [wdog_pkg::IRQ_W-1:0] irq_en, next_irq_en;
    logic [wdog_pkg::IRQ_W-1:0] irq_ev;
    logic next_irq, next_rst_req, next_nmi_req;
    logic next_ack_q;

    // Bus decode
    logic req, wr, rd_any;
    logic hit_wcfg, hit_wref, hit_wst, hit_icfg, hit_iref, hit_ist;
    logic hit_ist2, hit_iclr, hit_ien;

    // Per-watchdog control and observed state
    logic wdt_start, wdt_ref, wdt_clr_uf, wdt_clr_re;
    logic iwd_start, iwd_ref, iwd_clr_uf, iwd_clr_re;
    logic osc_tick, iwd_halt;
    logic [wdog_pkg::CNT_W-1:0] wdt_count, iwd_count;
    logic wdt_run, wdt_uf, wdt_re, wdt_uf_ev, wdt_re_ev;
    logic iwd_run, iwd_uf, iwd_re, iwd_uf_ev, iwd_re_ev;
    logic wdt_exp, iwd_exp;

    // A request is taken once, in the cycle before ack rises
    always_comb begin
        req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
        wr     = req && wb_we_i && (wb_sel_i != 4'h0);
        rd_any = req && !wb_we_i;
        hit_wcfg = wb_adr_i == wdog_pkg::WDT_CFG_ADDR;
        hit_wref = wb_adr_i == wdog_pkg::WDT_REFRESH_ADDR;
        hit_wst  = wb_adr_i == wdog_pkg::WDT_STATUS_ADDR;
        hit_icfg = wb_adr_i == wdog_pkg::IWD_CFG_ADDR;
        hit_iref = wb_adr_i == wdog_pkg::IWD_REFRESH_ADDR;
        hit_ist  = wb_adr_i == wdog_pkg::IWD_STATUS_ADDR;
        hit_ist2 = wb_adr_i == wdog_pkg::IRQ_STATUS_ADDR;
        hit_iclr = wb_adr_i == wdog_pkg::IRQ_CLEAR_ADDR;
        hit_ien  = wb_adr_i == wdog_pkg::IRQ_ENABLE_ADDR;
    end

    // Commands to the two watchdogs
    always_comb begin
        wdt_start  = wr && hit_wcfg && !wdt_lock; // RL10 RL9
        wdt_ref    = wr && hit_wref;
        wdt_clr_uf = wr && hit_wst && wb_dat_i[wdog_pkg::UNDERFLOW_BIT];
        wdt_clr_re = wr && hit_wst && wb_dat_i[wdog_pkg::REF_ERR_BIT];
        iwd_start  = 1'b0;
        iwd_ref    = wr && hit_iref; // RL6
        iwd_clr_uf = wr && hit_ist && wb_dat_i[wdog_pkg::UNDERFLOW_BIT];
        iwd_clr_re = wr && hit_ist && wb_dat_i[wdog_pkg::REF_ERR_BIT];
        // A strapped watchdog starts itself at the end of reset
        if (boot_pend) begin
            wdt_start = boot_wdt_en_i; // RL9
            iwd_start = boot_iwd_en_i; // RL9
        end
        osc_tick = independent_osc_clock_i && !osc_prev;
        iwd_halt = iwd_stop && low_power_i; // RL12
    end

    // Bus-clocked watchdog
    wdog_core #(
        .INDEP     (1'b0)
    ) u_wdt (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .cfg_i     (next_wdt_cfg),
        .tick_i    (1'b1),
        .start_i   (wdt_start),
        .refresh_i (wdt_ref),
        .halt_i    (1'b0),
        .clr_uf_i  (wdt_clr_uf),
        .clr_re_i  (wdt_clr_re),
        .count_o   (wdt_count),
        .run_o     (wdt_run),
        .uf_o      (wdt_uf),
        .re_o      (wdt_re),
        .uf_ev_o   (wdt_uf_ev),
        .re_ev_o   (wdt_re_ev)
    );

    // Oscillator-clocked watchdog, ticked on sampled rising edges
    wdog_core #(
        .INDEP     (1'b1)
    ) u_iwd (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .cfg_i     (next_iwd_cfg),
        .tick_i    (osc_tick),
        .start_i   (iwd_start),
        .refresh_i (iwd_ref),
        .halt_i    (iwd_halt),
        .clr_uf_i  (iwd_clr_uf),
        .clr_re_i  (iwd_clr_re),
        .count_o   (iwd_count),
        .run_o     (iwd_run),
        .uf_o      (iwd_uf),
        .re_o      (iwd_re),
        .uf_ev_o   (iwd_uf_ev),
        .re_ev_o   (iwd_re_ev)
    );

    // Configuration, lock and interrupt next values
    always_comb begin
        next_boot_pend = 1'b0;
        next_osc_prev  = independent_osc_clock_i;
        next_wdt_cfg   = wdt_cfg;
        next_iwd_cfg   = iwd_cfg;
        next_iwd_stop  = iwd_stop;
        next_wdt_lock  = wdt_lock;
        next_iwd_lock  = iwd_lock;
        next_irq_en    = irq_en;
        if (boot_pend) begin
            if (boot_wdt_en_i) begin
                next_wdt_cfg  = BOOT_WDT_CFG;
                next_wdt_lock = 1'b1; // RL9
            end
            if (boot_iwd_en_i) begin
                next_iwd_cfg  = BOOT_IWD_CFG;
                next_iwd_stop = BOOT_IWD_STOP;
                next_iwd_lock = 1'b1; // RL9
            end
        end else begin
            if (wr && hit_wcfg && !wdt_lock) begin
                next_wdt_cfg = wb_dat_i[wdog_pkg::CFG_W-1:0]; // RL9
            end
            if (wr && hit_icfg && !iwd_lock) begin
                next_iwd_cfg  = wb_dat_i[wdog_pkg::CFG_W-1:0]; // RL9
                next_iwd_stop = wb_dat_i[wdog_pkg::STOP_BIT];
            end
        end
        if (wr && hit_ien) begin
            next_irq_en = wb_dat_i[wdog_pkg::IRQ_W-1:0];
        end
        // Sticky event bits, set wins over clear
        irq_ev = {iwd_re_ev, iwd_uf_ev, wdt_re_ev, wdt_uf_ev};
        next_irq_stat = irq_stat;
        if (wr && hit_iclr) begin
            next_irq_stat = irq_stat & ~wb_dat_i[wdog_pkg::IRQ_W-1:0];
        end
        next_irq_stat = next_irq_stat | irq_ev;
        next_irq = |(next_irq_stat & next_irq_en);
        // Expiry is an underflow or a refused refresh
        wdt_exp = wdt_uf_ev || wdt_re_ev; // RL16 RL15
        iwd_exp = iwd_uf_ev || iwd_re_ev; // RL16 RL15
        next_rst_req = (wdt_exp && wdt_cfg.action == wdog_pkg::ACT_RESET)
                    || (iwd_exp && iwd_cfg.action == wdog_pkg::ACT_RESET); // RL3
        next_nmi_req = (wdt_exp && wdt_cfg.action == wdog_pkg::ACT_NMI)
                    || (iwd_exp && iwd_cfg.action == wdog_pkg::ACT_NMI); // RL3
    end

    // Read data and acknowledge
    always_comb begin
        next_ack = req;
        next_ack_q = next_ack;
        next_dat = 32'h0;
        if (rd_any) begin
            if (hit_wcfg) begin
                next_dat[wdog_pkg::CFG_W-1:0] = wdt_cfg;
                next_dat[wdog_pkg::LOCK_BIT]  = wdt_lock;
                next_dat[wdog_pkg::RUN_BIT]   = wdt_run;
            end else if (hit_icfg) begin
                next_dat[wdog_pkg::CFG_W-1:0] = iwd_cfg;
                next_dat[wdog_pkg::STOP_BIT]  = iwd_stop;
                next_dat[wdog_pkg::LOCK_BIT]  = iwd_lock;
                next_dat[wdog_pkg::RUN_BIT]   = iwd_run;
            end else if (hit_wst) begin
                next_dat[wdog_pkg::REF_ERR_BIT]   = wdt_re; // RL7
                next_dat[wdog_pkg::UNDERFLOW_BIT] = wdt_uf; // RL7
                next_dat[wdog_pkg::CNT_W-1:0]     = wdt_count; // RL7
            end else if (hit_ist) begin
                next_dat[wdog_pkg::REF_ERR_BIT]   = iwd_re; // RL7
                next_dat[wdog_pkg::UNDERFLOW_BIT] = iwd_uf; // RL7
                next_dat[wdog_pkg::CNT_W-1:0]     = iwd_count; // RL7
            end else if (hit_ist2) begin
                next_dat[wdog_pkg::IRQ_W-1:0] = irq_stat;
            end else if (hit_ien) begin
                next_dat[wdog_pkg::IRQ_W-1:0] = irq_en;
            end
        end
    end

    // Registers
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            wb_ack_o    <= 1'b0;
            wb_dat_o    <= 32'h0;
            wdt_cfg     <= wdog_pkg::CFG_RESET;
            iwd_cfg     <= wdog_pkg::CFG_RESET;
            iwd_stop    <= 1'b0;
            wdt_lock    <= 1'b0;
            iwd_lock    <= 1'b0;
            boot_pend   <= 1'b1;
            osc_prev    <= 1'b0;
            irq_stat    <= '0;
            irq_en      <= '0;
            irq_o       <= 1'b0;
            reset_req_o <= 1'b0;
            nmi_req_o   <= 1'b0;
        end else begin
            wb_ack_o    <= next_ack_q;
            wb_dat_o    <= next_dat;
            wdt_cfg     <= next_wdt_cfg;
            iwd_cfg     <= next_iwd_cfg;
            iwd_stop    <= next_iwd_stop;
            wdt_lock    <= next_wdt_lock;
            iwd_lock    <= next_iwd_lock;
            boot_pend   <= next_boot_pend;
            osc_prev    <= next_osc_prev;
            irq_stat    <= next_irq_stat;
            irq_en      <= next_irq_en;
            irq_o       <= next_irq;
            reset_req_o <= next_rst_req;
            nmi_req_o   <= next_nmi_req;
        end
    end
endmodule

// ===== tb/wdog_top_properties.sv
// Concurrent checks on the watchdog block's bus answers and requests
`timescale 1ns/1ps
module wdog_top_properties (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rstn_i,
    // Bus
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    // Requests
    input  wire logic        irq_o,
    input  wire logic        reset_req_o,
    input  wire logic        nmi_req_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    // Read cycle qualifier used by the data checks
    logic rd_ack;
    assign rd_ack = wb_ack_o && !wb_we_i;

    // Bus answer timing and data
    AST_ACK_ONE_CYCLE: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o [*2])
        else $error("ack longer than one cycle");
    AST_DAT_IDLE_ZERO: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    AST_UNMAPPED_READ: assert property (
        rd_ack && wb_adr_i >= 8'h24 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    AST_STATUS_UPPER: assert property (
        rd_ack && (wb_adr_i == wdog_pkg::WDT_STATUS_ADDR ||
        wb_adr_i == wdog_pkg::IWD_STATUS_ADDR) |-> wb_dat_o[31:16] == 16'h0)
        else $error("status word wider than 16 bits");
    AST_IRQ_STATUS_BITS: assert property (
        rd_ack && wb_adr_i == wdog_pkg::IRQ_STATUS_ADDR
        |-> wb_dat_o[31:4] == 28'h0)
        else $error("event status beyond four bits");

    // Expiry requests are single pulses; ack, irq and both requests are low after a reset cycle
    AST_RESET_PULSE: assert property (reset_req_o |=> !reset_req_o)
        else $error("reset request longer than one cycle");
    AST_NMI_PULSE: assert property (nmi_req_o |=> !nmi_req_o)
        else $error("nmi request longer than one cycle");
    AST_RESET_QUIET: assert property (@(posedge ref_clk_i) disable iff (1'b0)
        !rstn_i |=> !wb_ack_o && !irq_o && !reset_req_o && !nmi_req_o)
        else $error("outputs active after reset edge");

    // Main scenarios reached
    cover property (reset_req_o);
    cover property (nmi_req_o);
    cover property ($rose(irq_o));
endmodule

bind wdog_top wdog_top_properties chk (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .reset_req_o(reset_req_o), .nmi_req_o(nmi_req_o)
);

// ===== tb/wdog_top_tb.sv
// Self-checking bench for the windowed watchdog pair
`timescale 1ns/1ps
module wdog_top_tb;
    typedef struct packed {
        logic        we;
        logic [7:0]  adr;
        logic [31:0] dat;
        logic [31:0] expv;
    } row_type;

    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        osc = 1'b0;
    logic        low_power = 1'b0;
    logic        boot_wdt = 1'b0;
    logic        irq;
    logic        rst_req;
    logic        nmi_req;
    logic [31:0] q;
    logic [13:0] c;
    int          n;
    int          osc_cnt = 0;
    int          bad_count = 0;
    int          n_compared = 0;
    int          div_tbl [6] = '{4, 64, 128, 512, 2048, 8192};
    logic [31:0] win_cfg [3] = '{32'h020, 32'h3E0, 32'h3E0};
    int          win_wait [3] = '{0, 1100, 0};
    logic        win_err [3] = '{1'b1, 1'b1, 1'b0};

    // Reset values, enable width, unmapped place, oscillator config
    row_type rows [9] = '{
        '{1'b0, wdog_pkg::WDT_CFG_ADDR, 32'h0, 32'h0},
        '{1'b0, wdog_pkg::WDT_STATUS_ADDR, 32'h0, 32'h0},
        '{1'b0, wdog_pkg::IWD_STATUS_ADDR, 32'h0, 32'h0},
        '{1'b0, wdog_pkg::IRQ_STATUS_ADDR, 32'h0, 32'h0},
        '{1'b1, wdog_pkg::IRQ_ENABLE_ADDR, 32'h1F, 32'h0},
        '{1'b0, wdog_pkg::IRQ_ENABLE_ADDR, 32'h0, 32'hF},
        '{1'b1, 8'h24, 32'hFFFFFFFF, 32'h0},
        '{1'b0, 8'h24, 32'h0, 32'h0},
        '{1'b1, wdog_pkg::IWD_CFG_ADDR, 32'h4C0, 32'h0}};

    wdog_top uut (
        .ref_clk_i(ref_clk), .rstn_i(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .independent_osc_clock_i(osc),
        .low_power_i(low_power), .boot_wdt_en_i(boot_wdt),
        .boot_iwd_en_i(1'b0), .irq_o(irq), .reset_req_o(rst_req),
        .nmi_req_o(nmi_req));

    // Bus clock and an oscillator eight bus cycles long
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        osc_cnt <= (osc_cnt == 3) ? 0 : osc_cnt + 1;
        if (osc_cnt == 3) begin
            osc <= ~osc;
        end
    end

    task automatic end_of_test;
        if (bad_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] e,
                         input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", what, e, g);
            bad_count++;
        end
    endtask

    // One classic Wishbone cycle; read data lands in q
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (ack !== 1'b1) begin
            check("bus ack", 32'h1, 32'(ack));
            end_of_test();
        end
    endtask

    task automatic idle(input int cnt);
        repeat (cnt) @(posedge ref_clk);
    endtask

    // Bounded wait for an expiry pulse; k is edges waited
    task automatic wait_req(input logic nmi, input int lim, output int k);
        k = 0;
        while (((nmi ? nmi_req : rst_req) !== 1'b1) && k < lim) begin
            @(posedge ref_clk);
            k++;
        end
    endtask

    task automatic do_reset;
        rstn <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask

    initial begin
        do_reset();
        foreach (rows[i]) begin
            bus(rows[i].we, rows[i].adr, rows[i].dat);
            if (!rows[i].we) check("row read", rows[i].expv, q);
        end
        // Timeout loads and divider rates
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, wdog_pkg::WDT_CFG_ADDR, 32'hC0 | i);
            bus(1'b0, wdog_pkg::WDT_STATUS_ADDR, 32'h0);
            n = (1024 << (i == 0 ? 0 : i + 1)) - 1;
            check("tmo load", n, q[13:0]);
        end
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, wdog_pkg::WDT_CFG_ADDR, 32'hC3 | (i << 2));
            idle(2 * div_tbl[i]);
            bus(1'b0, wdog_pkg::WDT_STATUS_ADDR, 32'h0);
            check("div rate", 32'h3FFD, q[13:0]);
        end
        // Start by config, underflow, flags and interrupt
        bus(1'b1, wdog_pkg::WDT_CFG_ADDR, 32'hC0);
        bus(1'b0, wdog_pkg::WDT_CFG_ADDR, 32'h0);
        check("wdt run", 32'h400000C0, q);
        wait_req(1'b0, 5000, n);
        check("wdt period", 1, n >= 4086 && n <= 4100);
        if (n == 5000) end_of_test();
        bus(1'b0, wdog_pkg::WDT_STATUS_ADDR, 32'h0);
        check("uf flag", 32'h1, q[15:14]);
        bus(1'b0, wdog_pkg::IRQ_STATUS_ADDR, 32'h0);
        check("irq status", 32'h1, q);
        check("irq level", 32'h1, irq);
        bus(1'b1, wdog_pkg::IRQ_ENABLE_ADDR, 32'h0);
        idle(2);
        check("irq masked", 32'h0, irq);
        bus(1'b1, wdog_pkg::IRQ_ENABLE_ADDR, 32'hF);
        bus(1'b0, wdog_pkg::WDT_STATUS_ADDR, 32'h0);
        check("uf sticky", 32'h1, q[14]);
        check("irq unmasked", 32'h1, irq);
        bus(1'b1, wdog_pkg::WDT_STATUS_ADDR, 32'h4000);
        bus(1'b1, wdog_pkg::IRQ_CLEAR_ADDR, 32'h1);
        bus(1'b0, wdog_pkg::WDT_STATUS_ADDR, 32'h0);
        check("uf cleared", 32'h0, q[15:14]);
        check("irq cleared", 32'h0, irq);
        // Valid refresh reloads the counter
        bus(1'b1, wdog_pkg::WDT_CFG_ADDR, 32'hC0);
        idle(2000);
        bus(1'b1, wdog_pkg::WDT_REFRESH_ADDR, 32'h0);
        bus(1'b0, wdog_pkg::WDT_STATUS_ADDR, 32'h0);
        check("reload", 1, q[15] == 1'b0 && q[13:0] >= 14'h3FC);
        // Early refresh, late refresh, refresh inside the window
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, wdog_pkg::WDT_STATUS_ADDR, 32'hC000);
            bus(1'b1, wdog_pkg::WDT_CFG_ADDR, win_cfg[i]);
            idle(win_wait[i]);
            bus(1'b1, wdog_pkg::WDT_REFRESH_ADDR, 32'h0);
            wait_req(1'b1, 6, n);
            check("window nmi", 32'(win_err[i]), 32'(n < 6));
            bus(1'b0, wdog_pkg::WDT_STATUS_ADDR, 32'h0);
            check("window flag", 32'(win_err[i]), q[15]);
        end
        // Oscillator watchdog: refresh starts, halt, divide by one
        bus(1'b1, wdog_pkg::IWD_REFRESH_ADDR, 32'h0);
        bus(1'b0, wdog_pkg::IWD_CFG_ADDR, 32'h0);
        check("iwd start", 32'h400004C0, q);
        low_power <= 1'b1;
        idle(3);
        bus(1'b0, wdog_pkg::IWD_STATUS_ADDR, 32'h0);
        c = q[13:0];
        idle(200);
        bus(1'b0, wdog_pkg::IWD_STATUS_ADDR, 32'h0);
        check("iwd halt", 32'(c), q[13:0]);
        low_power <= 1'b0;
        idle(200);
        bus(1'b0, wdog_pkg::IWD_STATUS_ADDR, 32'h0);
        check("iwd rate", 1, (c - q[13:0]) inside {[24:27]});
        // Oscillator watchdog refreshed too early raises an NMI
        bus(1'b1, wdog_pkg::IWD_CFG_ADDR, 32'h020);
        bus(1'b1, wdog_pkg::IWD_REFRESH_ADDR, 32'h0);
        wait_req(1'b1, 6, n);
        check("iwd window", 1, n < 6);
        bus(1'b0, wdog_pkg::IWD_STATUS_ADDR, 32'h0);
        check("iwd flag", 32'h1, q[15]);
        // Boot-enabled watchdog ignores config writes
        boot_wdt <= 1'b1;
        do_reset();
        bus(1'b1, wdog_pkg::WDT_CFG_ADDR, 32'hC3);
        bus(1'b0, wdog_pkg::WDT_CFG_ADDR, 32'h0);
        check("boot lock", 32'hC0000000, q);
        end_of_test();
    end
endmodule
